// ### rtl/pmc_cfg.svh
// Constants for the port mode configuration block
// Operation
// R1 - Port 1 autoswitch enabled at power-up
// R2 - Autoswitch picks AUI without link, TP with
// R3 - Medium change waits for packet end
// R4 - Jabbering link fail waits for unjab end
// R5 - Packet data drives only selected medium outputs
// R6 - AUI selected: TP sends link pulses only
// R7 - AUI needs powerup time; TP immediate
// R8 - Management off: MDC loopback, MDIO link4
// R9 - Full duplex never asserts collision
// R10 - Normal mode: duplex pins sampled at reset
// R11 - Control bit D12 changes duplex at runtime
// R12 - Enhanced mode: duplex pins act immediately
// R13 - Second collision strap selects duplex mode
// R14 - Fourth collision strap selects RXC gating
// R15 - Third collision strap disables receive filter
// R16 - Carrier sense straps give management address
// R17 - Fourth receive data strap: autonegotiation
// R18 - Receive data and link straps: MAC mode
// R19 - Straps sampled on hardware reset only
// R20 - Board holds straps ten clocks after reset
// R21 - D15 write resets only that port
// R22 - Advertise half and full duplex by default
// R23 - Straps held until next hardware reset
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_NPORT 4
`define PMC_CLK_MHZ 125
`define PMC_AUI_PWRUP_US 2000
`define PMC_STRAP_WAIT 2'h3
`define PMC_PRE_ONES 6'h20
`define PMC_HDR_BITS 4'hd
`define PMC_DATA_BITS 5'h10
`define PMC_REG_ANAR 5'h04
`define PMC_REG_GLOBAL 5'h05
`define PMC_OP_RD 2'h2
`define PMC_OP_WR 2'h1
`define PMC_B_RST 15
`define PMC_B_FDX 12
`define PMC_B_MEDIUM_AUTOSWITCH_ENABLE 11
`define PMC_B_MANAUI 10
`define PMC_B_AUISEL 1
`define PMC_B_LINK 0
`define PMC_ANAR_RST 16'h0003
`define PMC_PHY_HI 2'h0
`endif

// ### rtl/pmc_pkg.sv
// Types for the port mode configuration block
package pmc_pkg;
    typedef struct packed {
        logic gate_rxc_5;
        logic rx_filter_off;
        logic dpx_normal;
        logic led_normal;
        logic [2:0] tcvr_addr;
        logic an_enable;
        logic [3:0] mac_if_mode;
    } pmc_strap_t;
    typedef enum {M_PRE, M_HDR, M_TA, M_DATA} pmc_mdio_st_t;
endpackage : pmc_pkg

// ### rtl/pmc_top.sv
// Strap capture, duplex, port 1 medium switch and management slave
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_top #(
    parameter int AUI_PWRUP_CYC = `PMC_AUI_PWRUP_US * `PMC_CLK_MHZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] col_straps,
    input wire logic [2:0] tcvr_address_straps,
    input wire logic [3:0] rxd_straps,
    input wire logic mac_if_mode_extra_strap,
    input wire logic [3:0] per_port_duplex_pins,
    input wire logic mdc_pin,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [3:0] link_ok,
    input wire logic [3:0] port_tx_active,
    input wire logic [3:0] port_rx_active,
    input wire logic p1_jabber,
    input wire logic p1_tx_en,
    input wire logic p1_tx_data,
    output logic p1_tp_tx_en,
    output logic p1_tp_tx_data,
    output logic p1_aui_tx_en,
    output logic p1_aui_tx_data,
    output logic p1_tp_link_pulse_en,
    output logic p1_aui_power_en,
    output logic p1_aui_ready,
    output logic p1_aui_selected,
    output logic [3:0] port_full_duplex,
    output logic [3:0] port_collision,
    output logic [3:0] port_soft_reset,
    output logic loopback_sel,
    output logic [1:0] an_advert,
    output var pmc_pkg::pmc_strap_t straps
);
    import pmc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [18:0] pin_s1_r;
    logic [18:0] pin_s2_r;
    logic [1:0] mgmt_s1_r;
    logic [1:0] mgmt_s2_r;
    logic mdc_d_r;
    logic mdc_rise;
    logic [3:0] dpx_pin;
    logic [3:0] col_pin;
    logic [2:0] addr_pin;
    logic [3:0] rxd_pin;
    logic lnk_pin;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= 19'h7ffff;
            pin_s2_r <= 19'h7ffff;
            mgmt_s1_r <= 2'h3;
            mgmt_s2_r <= 2'h3;
            mdc_d_r <= 1'h1;
        end else begin
            pin_s1_r <= {per_port_duplex_pins, col_straps,
                tcvr_address_straps, rxd_straps,
                mac_if_mode_extra_strap, 3'h0};
            pin_s2_r <= pin_s1_r;
            mgmt_s1_r <= {mdc_pin, mdio_in};
            mgmt_s2_r <= mgmt_s1_r;
            mdc_d_r <= mgmt_s2_r[1];
        end
    end

    assign dpx_pin = pin_s2_r[18:15];
    assign col_pin = pin_s2_r[14:11];
    assign addr_pin = pin_s2_r[10:8];
    assign rxd_pin = pin_s2_r[7:4];
    assign lnk_pin = pin_s2_r[3];
    assign mdc_rise = mgmt_s2_r[1] & ~mdc_d_r;

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic [1:0] strap_cnt_r;
    logic strap_done_r;
    logic strap_take;
    logic [3:0] dpx_strap_r;
    logic mgmt_off;

    assign strap_take = ~strap_done_r && strap_cnt_r == `PMC_STRAP_WAIT;
    assign mgmt_off = ~straps.dpx_normal;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'h0;
            straps <= '1; // R19
            dpx_strap_r <= 4'hf;
        end else if (strap_take) begin
            strap_done_r <= 1'h1; // R23
            straps.gate_rxc_5 <= col_pin[3]; // R14
            straps.rx_filter_off <= col_pin[2]; // R15
            straps.dpx_normal <= col_pin[1]; // R13
            straps.led_normal <= col_pin[0];
            straps.tcvr_addr <= addr_pin; // R16
            straps.an_enable <= ~rxd_pin[3]; // R17
            straps.mac_if_mode <= {rxd_pin[2:0], lnk_pin}; // R18
            dpx_strap_r <= dpx_pin; // R10
        end else if (~strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Management serial slave
    // ------------------------------------------------------------
    pmc_mdio_st_t mst_r;
    logic [5:0] pre_cnt_r;
    logic [4:0] bit_cnt_r;
    logic [12:0] hdr_r;
    logic [15:0] sh_r;
    logic wr_stb_r;
    logic [4:0] wr_addr_r;
    logic [15:0] wr_data_r;
    logic is_rd_r;
    logic hit;
    logic [15:0] rd_data;
    logic mdio_bit;

    assign mdio_bit = mgmt_s2_r[0];
    assign hit = hdr_r[9:5] == {`PMC_PHY_HI, straps.tcvr_addr};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mst_r <= M_PRE;
            pre_cnt_r <= 6'h0;
            bit_cnt_r <= 5'h0;
            hdr_r <= 13'h0;
            sh_r <= 16'h0;
            is_rd_r <= 1'h0;
            wr_stb_r <= 1'h0;
            wr_addr_r <= 5'h0;
            wr_data_r <= 16'h0;
        end else begin
            wr_stb_r <= 1'h0;
            if (mdc_rise && !mgmt_off) begin // R8
                unique case (mst_r)
                    M_PRE: begin
                        if (mdio_bit) begin
                            if (pre_cnt_r != `PMC_PRE_ONES)
                                pre_cnt_r <= pre_cnt_r + 6'h1;
                        end else if (pre_cnt_r == `PMC_PRE_ONES) begin
                            mst_r <= M_HDR;
                            bit_cnt_r <= 5'h0;
                        end else begin
                            pre_cnt_r <= 6'h0;
                        end
                    end
                    M_HDR: begin
                        hdr_r <= {hdr_r[11:0], mdio_bit};
                        bit_cnt_r <= bit_cnt_r + 5'h1;
                        if (bit_cnt_r == 5'({1'h0, `PMC_HDR_BITS}) - 5'h1)
                        begin
                            mst_r <= M_TA;
                            bit_cnt_r <= 5'h0;
                        end
                    end
                    M_TA: begin
                        bit_cnt_r <= bit_cnt_r + 5'h1;
                        is_rd_r <= hdr_r[12] && hit &&
                            hdr_r[11:10] == `PMC_OP_RD;
                        if (bit_cnt_r == 5'h1) begin
                            mst_r <= M_DATA;
                            bit_cnt_r <= 5'h0;
                            sh_r <= rd_data;
                        end
                    end
                    M_DATA: begin
                        sh_r <= {sh_r[14:0], mdio_bit};
                        bit_cnt_r <= bit_cnt_r + 5'h1;
                        if (bit_cnt_r == `PMC_DATA_BITS - 5'h1) begin
                            mst_r <= M_PRE;
                            pre_cnt_r <= 6'h0;
                            wr_stb_r <= hdr_r[12] && hit &&
                                hdr_r[11:10] == `PMC_OP_WR;
                            wr_addr_r <= hdr_r[4:0];
                            wr_data_r <= {sh_r[14:0], mdio_bit};
                        end
                    end
                endcase
            end
        end
    end

    // Pin drive: read data, or link 4 when management is off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mdio_out <= 1'h0;
            mdio_oe <= 1'h0;
            loopback_sel <= 1'h0;
        end else if (mgmt_off) begin
            mdio_out <= link_ok[3]; // R8
            mdio_oe <= 1'h1; // R8
            loopback_sel <= mgmt_s2_r[1]; // R8
        end else begin
            loopback_sel <= 1'h0;
            mdio_oe <= is_rd_r && (mst_r == M_DATA ||
                (mst_r == M_TA && bit_cnt_r == 5'h1));
            mdio_out <= mst_r == M_DATA ? sh_r[15] : 1'h0;
        end
    end

    // ------------------------------------------------------------
    // Port control registers and duplex
    // ------------------------------------------------------------
    logic p1_medium_autoswitch_enable_r;
    logic p1_manaui_r;

    always_comb begin
        rd_data = 16'h0;
        if (hdr_r[4:0] < 5'(`PMC_NPORT)) begin
            rd_data[`PMC_B_FDX] = port_full_duplex[hdr_r[1:0]];
            rd_data[`PMC_B_LINK] = link_ok[hdr_r[1:0]];
            if (hdr_r[1:0] == 2'h0) begin
                rd_data[`PMC_B_MEDIUM_AUTOSWITCH_ENABLE] = p1_medium_autoswitch_enable_r;
                rd_data[`PMC_B_MANAUI] = p1_manaui_r;
                rd_data[`PMC_B_AUISEL] = p1_aui_selected;
            end
        end else if (hdr_r[4:0] == `PMC_REG_ANAR) begin
            rd_data[1:0] = an_advert;
        end else if (hdr_r[4:0] == `PMC_REG_GLOBAL) begin
            rd_data[11:0] = straps;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PMC_NPORT; gi++) begin : g_port
            logic wr_me;
            assign wr_me = wr_stb_r && wr_addr_r == 5'(gi);
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    port_full_duplex[gi] <= 1'h0;
                    port_soft_reset[gi] <= 1'h0;
                end else begin
                    port_soft_reset[gi] <= wr_me &&
                        wr_data_r[`PMC_B_RST]; // R21
                    if (strap_take)
                        port_full_duplex[gi] <= ~dpx_pin[gi]; // R10
                    else if (strap_done_r && mgmt_off)
                        port_full_duplex[gi] <= ~dpx_pin[gi]; // R12
                    else if (wr_me && wr_data_r[`PMC_B_RST])
                        port_full_duplex[gi] <= ~dpx_strap_r[gi]; // R21
                    else if (wr_me)
                        port_full_duplex[gi] <=
                            wr_data_r[`PMC_B_FDX]; // R11
                end
            end
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst)
                    port_collision[gi] <= 1'h0;
                else
                    port_collision[gi] <= port_tx_active[gi] &&
                        port_rx_active[gi] &&
                        !port_full_duplex[gi]; // R9
            end
        end
    endgenerate

    // Advertisement register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            an_advert <= 2'(`PMC_ANAR_RST); // R22
        else if (wr_stb_r && wr_addr_r == `PMC_REG_ANAR)
            an_advert <= wr_data_r[1:0];
    end

    // Port 1 medium control bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            p1_medium_autoswitch_enable_r <= 1'h1; // R1
            p1_manaui_r <= 1'h0;
        end else if (wr_stb_r && wr_addr_r == 5'h0) begin
            if (wr_data_r[`PMC_B_RST]) begin
                p1_medium_autoswitch_enable_r <= 1'h1; // R1
                p1_manaui_r <= 1'h0;
            end else begin
                p1_medium_autoswitch_enable_r <= wr_data_r[`PMC_B_MEDIUM_AUTOSWITCH_ENABLE];
                p1_manaui_r <= wr_data_r[`PMC_B_MANAUI];
            end
        end
    end

    // ------------------------------------------------------------
    // Port 1 medium switch
    // ------------------------------------------------------------
    logic want_aui;
    logic p1_busy;
    logic [31:0] pwr_cnt_r;

    assign want_aui = p1_medium_autoswitch_enable_r ? ~link_ok[0] : p1_manaui_r; // R2
    assign p1_busy = port_tx_active[0] | port_rx_active[0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            p1_aui_selected <= 1'h0;
        end else if (!p1_busy) begin // R3
            if (want_aui && !p1_jabber)
                p1_aui_selected <= 1'h1; // R4
            else if (!want_aui)
                p1_aui_selected <= 1'h0; // R2
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            p1_aui_power_en <= 1'h0;
            p1_aui_ready <= 1'h0;
            pwr_cnt_r <= 32'h0;
        end else if (!p1_aui_selected) begin
            p1_aui_power_en <= 1'h0; // R7
            p1_aui_ready <= 1'h0;
            pwr_cnt_r <= 32'h0;
        end else begin
            p1_aui_power_en <= 1'h1;
            if (pwr_cnt_r == 32'(AUI_PWRUP_CYC))
                p1_aui_ready <= 1'h1; // R7
            else
                pwr_cnt_r <= pwr_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            p1_tp_tx_en <= 1'h0;
            p1_tp_tx_data <= 1'h0;
            p1_aui_tx_en <= 1'h0;
            p1_aui_tx_data <= 1'h0;
            p1_tp_link_pulse_en <= 1'h0;
        end else begin
            p1_tp_tx_en <= p1_tx_en && !p1_aui_selected; // R5
            p1_tp_tx_data <= p1_tx_data && !p1_aui_selected; // R5
            p1_aui_tx_en <= p1_tx_en && p1_aui_selected; // R5
            p1_aui_tx_data <= p1_tx_data && p1_aui_selected; // R5
            p1_tp_link_pulse_en <= 1'h1; // R6
        end
    end
endmodule : pmc_top
`default_nettype wire

// ### tb/pmc_props.sv
// Assertions on the port mode configuration block ports
`timescale 1ns/1ps
`default_nettype none
module pmc_props #(
    parameter int AUI_PWRUP_CYC = 10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] link_ok,
    input wire logic [3:0] port_tx_active,
    input wire logic [3:0] port_rx_active,
    input wire logic p1_jabber,
    input wire logic p1_tp_tx_en,
    input wire logic p1_tp_link_pulse_en,
    input wire logic p1_aui_power_en,
    input wire logic p1_aui_ready,
    input wire logic p1_aui_selected,
    input wire logic [3:0] port_full_duplex,
    input wire logic [3:0] port_collision,
    input wire logic [3:0] port_soft_reset,
    input wire logic mdio_oe,
    input wire logic mdio_out,
    input wire logic [1:0] an_advert,
    input wire pmc_pkg::pmc_strap_t straps
);
    import pmc_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_want_aui;
        !link_ok[0] && !p1_jabber && !port_tx_active[0] && !port_rx_active[0];
    endsequence
    sequence s_want_tp;
        link_ok[0] && !port_tx_active[0] && !port_rx_active[0];
    endsequence
    chk_aui_enter: assert property (!p1_aui_selected ##0 s_want_aui |=>
        p1_aui_selected) else $error("aui not entered");
    chk_switch_idle: assert property ($changed(p1_aui_selected) |->
        $past(!(port_tx_active[0] || port_rx_active[0])))
        else $error("medium changed mid packet");
    chk_jabber_hold: assert property ($rose(p1_aui_selected) |->
        !$past(p1_jabber)) else $error("aui entered while jabbering");
    chk_tp_return: assert property (p1_aui_selected ##0 s_want_tp |=>
        !p1_aui_selected) else $error("tp return late");
    chk_route_aui: assert property (p1_aui_selected |-> !p1_tp_tx_en)
        else $error("tp carries data on aui");
    chk_link_pulse: assert property (!$past(rst) |-> p1_tp_link_pulse_en)
        else $error("link pulses stopped");
    chk_power_lag: assert property (!$past(rst) |->
        p1_aui_power_en == $past(p1_aui_selected)) else $error("aui power");
    chk_ready_wait: assert property ($rose(p1_aui_power_en) |->
        !p1_aui_ready [*8]) else $error("aui ready too early");
    chk_no_col: assert property (!$past(rst) |-> port_collision ==
        $past(port_tx_active & port_rx_active & ~port_full_duplex))
        else $error("collision mismatch");
    chk_soft_pulse: assert property (port_soft_reset != 4'h0 |=>
        port_soft_reset == 4'h0) else $error("soft reset not a pulse");
    chk_mgmt_off: assert property (!straps.dpx_normal |=> mdio_oe &&
        mdio_out == $past(link_ok[3])) else $error("link 4 not on mdio");
    chk_adv_reset: assert property ($fell(rst) |-> an_advert == 2'h3)
        else $error("advert reset value");
endmodule : pmc_props
bind pmc_top pmc_props #(.AUI_PWRUP_CYC(AUI_PWRUP_CYC)) chk_u (
    .ref_clk, .rst, .link_ok, .port_tx_active, .port_rx_active, .p1_jabber,
    .p1_tp_tx_en, .p1_tp_link_pulse_en, .p1_aui_power_en, .p1_aui_ready,
    .p1_aui_selected, .port_full_duplex, .port_collision, .port_soft_reset,
    .mdio_oe, .mdio_out, .an_advert, .straps
);
`default_nettype wire

// ### tb/pmc_station.sv
// Management station model with the data line pull-up
`timescale 1ns/1ps
`default_nettype none
module pmc_station (
    input wire logic ref_clk,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output var logic mdc_pin,
    output wire logic mdio_in
);
    logic st_oe = 1'b0;
    logic st_d = 1'b1;
    // Released line rests at the pull-up level
    assign mdio_in = mdio_oe ? mdio_out : (st_oe ? st_d : 1'b1);
    initial mdc_pin = 1'b0;
    task automatic xfer(input logic rd, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rv);
        logic [63:0] f;
        f = {32'hffff_ffff, 2'h1, rd ? 2'h2 : 2'h1, phy, ra,
            rd ? 2'h3 : 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            mdc_pin = 1'b0;
            st_oe = !(rd && i < 18);
            st_d = f[i];
            repeat (4) @(posedge ref_clk);
            #1;
            rv = {rv[14:0], mdio_in};
            mdc_pin = 1'b1;
            repeat (4) @(posedge ref_clk);
            #1;
        end
    endtask : xfer
endmodule : pmc_station
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the port mode configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmc_pkg::*;
    localparam int PWR = 10;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] col_straps, rxd_straps, per_port_duplex_pins, dx0;
    logic [2:0] tcvr_address_straps;
    logic mac_if_mode_extra_strap, p1_jabber, p1_tx_en, p1_tx_data;
    logic [3:0] link_ok, port_tx_active, port_rx_active;
    logic mdc_pin, mdio_in, mdio_out, mdio_oe, loopback_sel;
    logic p1_tp_tx_en, p1_tp_tx_data, p1_aui_tx_en, p1_aui_tx_data;
    logic p1_tp_link_pulse_en, p1_aui_power_en, p1_aui_ready, p1_aui_selected;
    logic [3:0] port_full_duplex, port_collision, port_soft_reset;
    logic [1:0] an_advert;
    logic [4:0] ph;
    logic [15:0] rv;
    logic [3:0] sr_seen;
    pmc_strap_t straps, es;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #4 ref_clk = ~ref_clk;
    // Collects every soft reset pulse seen since the last reset
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sr_seen <= 4'h0;
        end else begin
            sr_seen <= sr_seen | port_soft_reset;
        end
    end
    pmc_top #(.AUI_PWRUP_CYC(PWR)) dut_u (
        .ref_clk, .rst, .col_straps, .tcvr_address_straps, .rxd_straps,
        .mac_if_mode_extra_strap, .per_port_duplex_pins, .mdc_pin, .mdio_in,
        .mdio_out, .mdio_oe, .link_ok, .port_tx_active, .port_rx_active,
        .p1_jabber, .p1_tx_en, .p1_tx_data, .p1_tp_tx_en, .p1_tp_tx_data,
        .p1_aui_tx_en, .p1_aui_tx_data, .p1_tp_link_pulse_en,
        .p1_aui_power_en, .p1_aui_ready, .p1_aui_selected, .port_full_duplex,
        .port_collision, .port_soft_reset, .loopback_sel, .an_advert, .straps
    );
    pmc_station station_u (.ref_clk, .mdio_out, .mdio_oe, .mdc_pin, .mdio_in);
    function automatic pmc_strap_t exp_straps();
        return {col_straps, tcvr_address_straps, ~rxd_straps[3],
            rxd_straps[2:0], mac_if_mode_extra_strap};
    endfunction : exp_straps
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    task automatic do_reset(input logic mg);
        rst = 1'b1;
        col_straps = {2'($urandom), mg, 1'($urandom)};
        {tcvr_address_straps, rxd_straps} = 7'($urandom);
        {mac_if_mode_extra_strap, per_port_duplex_pins} = 5'($urandom);
        dx0 = per_port_duplex_pins;
        es = exp_straps();
        ph = {2'h0, tcvr_address_straps};
        tick(6);
        rst = 1'b0;
        tick(10);
        chk("straps", 16'(es), 16'(straps));
        chk("duplex", {12'h0, ~dx0}, 16'(port_full_duplex));
        chk("advert", 16'h3, 16'(an_advert));
        {col_straps, rxd_straps, tcvr_address_straps} = 11'($urandom);
        tick(8);
        chk("straps held", 16'(es), 16'(straps));
    endtask : do_reset
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        void'($urandom(78557));
        {link_ok, port_tx_active, port_rx_active} = 12'hf00;
        {p1_jabber, p1_tx_en, p1_tx_data} = 3'h0;
        do_reset(1'b1);
        per_port_duplex_pins = ~dx0;
        tick(6);
        chk("fdx held", {12'h0, ~dx0}, 16'(port_full_duplex));
        station_u.xfer(1'b1, ph, 5'h05, 16'h0, rv);
        chk("strap reg", 16'(es), {4'h0, rv[11:0]});
        station_u.xfer(1'b1, ph, 5'h00, 16'h0, rv);
        chk("medium_autoswitch_enable", 16'h1, 16'(rv[11]));
        station_u.xfer(1'b1, ph, 5'h04, 16'h0, rv);
        chk("advert reg", 16'h0003, rv);
        station_u.xfer(1'b1, ph ^ 5'h01, 5'h04, 16'h0, rv);
        chk("other addr", 16'hffff, rv);
        for (int p = 0; p < 4; p++) begin
            station_u.xfer(1'b0, ph, 5'(p), {3'h0, ~port_full_duplex[p],
                p == 0, 11'h0}, rv);
            tick(2);
            chk("fdx write", {15'h0, dx0[p]},
                16'(port_full_duplex[p]));
        end
        {port_tx_active, port_rx_active, p1_tx_en} = 9'h1ff;
        tick(2);
        chk("collision", {12'h0, ~dx0}, 16'(port_collision));
        chk("tp data", 16'h1, 16'(p1_tp_tx_en));
        station_u.xfer(1'b0, ph, 5'h02, 16'h9000, rv);
        tick(2);
        chk("soft reset", {15'h0, ~dx0[2]}, 16'(port_full_duplex[2]));
        chk("straps kept", 16'(es), 16'(straps));
        chk("soft pulse", 16'h4, 16'(sr_seen));
        {port_tx_active, port_rx_active, link_ok[0]} = 9'h020;
        tick(5);
        chk("busy hold", 16'h0, 16'(p1_aui_selected));
        {port_tx_active[0], p1_tx_en, p1_jabber} = 3'h1;
        tick(5);
        chk("jabber hold", 16'h0, 16'(p1_aui_selected));
        p1_jabber = 1'b0;
        tick(3);
        chk("aui select", 16'h1, 16'(p1_aui_selected));
        chk("aui early", 16'h0, 16'(p1_aui_ready));
        {port_tx_active[0], p1_tx_en, p1_tx_data} = 3'h7;
        tick(2);
        chk("aui path", 16'h3, {14'h0, p1_aui_tx_en, p1_aui_tx_data});
        chk("tp path", 16'h4, {13'h0, p1_tp_link_pulse_en,
            p1_tp_tx_en, p1_tp_tx_data});
        tick(PWR);
        chk("aui ready", 16'h1, 16'(p1_aui_ready));
        link_ok[0] = 1'b1;
        tick(3);
        chk("busy keep", 16'h1, 16'(p1_aui_selected));
        {port_tx_active[0], p1_tx_en} = 2'h0;
        tick(2);
        chk("tp return", 16'h0, 16'(p1_aui_selected));
        for (int i = 0; i < 300; i++) begin
            {link_ok, port_tx_active, port_rx_active, p1_tx_data} =
                13'($urandom);
            p1_tx_en = port_tx_active[0];
            tick(1);
        end
        do_reset(1'b0);
        for (int i = 0; i < 4; i++) begin
            per_port_duplex_pins = 4'($urandom);
            tick(6);
            chk("pin fdx", {12'h0, ~per_port_duplex_pins},
                16'(port_full_duplex));
        end
        for (int i = 0; i < 2; i++) begin
            station_u.mdc_pin = (i == 0);
            tick(6);
            chk("loopback", 16'(i == 0), 16'(loopback_sel));
        end
        link_ok[3] = 1'b0;
        station_u.xfer(1'b1, ph, 5'h04, 16'h0, rv);
        chk("mgmt off", 16'h0, rv);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
